// ---- shac_pkg.sv ----
// Constants and types for the storage horizontal address controller
package shac_pkg;
   localparam int CLK_HZ         = 20_000_000;
   localparam int CLK_PERIOD_NS  = 50;
   localparam int BASE_HZ        = 1_000_000;
   // Down-count rate is the base clock halved
   localparam int DOWN_DIV       = 2 * (CLK_HZ / BASE_HZ);
   localparam int DIV_W          = 6;
   localparam int FLOAT_CYC      = 8;
   localparam int FLT_W          = 4;
   localparam int CURSOR_TIME_NS = 10_000;
   localparam int CURSOR_CYC     = (CURSOR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CUR_W          = 8;
   localparam int TRK_W          = 10;
   localparam int DSP_W          = 9;
   localparam int ADR_W          = 10;
   localparam int DAT_W          = 8;
   localparam int MEM_DEPTH      = 1024;
   localparam int BSEL_W         = 3;
   localparam logic [TRK_W-1:0] TRK_RST = 10'h000;
   localparam logic [TRK_W-1:0] TRK_MAX = 10'h3FF;
   // Positions in the synchronised input vector
   localparam int IN_SYNC  = 0;
   localparam int IN_UP    = 1;
   localparam int IN_DN    = 2;
   localparam int IN_OVF   = 3;
   localparam int IN_UNF   = 4;
   localparam int IN_BREQ  = 5;
   localparam int IN_CW    = 6;
   localparam int IN_STEP  = 7;
   localparam int IN_RW    = 8;
   localparam int IN_SAVE  = 9;
   localparam int IN_ACQ   = 10;
   localparam int IN_CMAT  = 11;
   localparam int IN_MARK  = 12;
   localparam int IN_CSW   = 13;
   localparam int IN_N     = IN_CSW + DAT_W;
   typedef enum logic [3:0] {
      ST_ACQ = 4'b0001,
      ST_DSP = 4'b0010,
      ST_REQ = 4'b0100,
      ST_GNT = 4'b1000
   } shac_state_e;
endpackage : shac_pkg

// ---- shac_sync3.sv ----
// Three-stage input synchroniser that accepts a change once the last two stages agree
module shac_sync3 #(
   parameter int W = 1
) (
   input  wire logic         mclk_i,    // System clock
   input  wire logic         sys_rst_i, // Synchronous reset
   input  wire logic [W-1:0] d_i,       // Asynchronous inputs
   output logic      [W-1:0] q_o        // Filtered inputs
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
   logic [W-1:0] q_next;
   genvar g;

   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_comb begin
            q_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : q_reg[g];
         end
      end
   endgenerate

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg  <= '0;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg  <= q_next;
      end
   end

   assign q_o = q_reg;
endmodule : shac_sync3

// ---- shac_ctrl.sv ----
// Horizontal address control for the digital trace store
// Function
// - Constant bit is picked by a mux on the three lowest address bits.
// - Tracking counter counts up on rightward sweep, down on retrace.
// - Each up-count gives a new X value and a divide start strobe.
// - Up-counts clock on sync, down-counts on base 1 MHz halved.
// - Save-first mode skips every other value, giving odd addresses only.
// - Controller pulls request low and floats address for eight cycles.
// - Tracking value is copied into the holding register during acquisition.
// - During display a 9-bit counter counts sync pulses for X.
// - State logic select picks holding register or display counter.
// - Host address counter clears on control write, steps on step pulse.
// - Host address and read/write reach memory only during grant.
// - Up and down comparator inputs set counter direction.
// - Overflow and underflow stop counting past the limits.
// - Trace valid is high for valid display data, low on retrace.
// - Cursor pulse holds the display counter to brighten the point.
// - Cursor pulse length is a counter armed while trace valid is low.
// - Retrace from first to second trace blanked on marker cycles.
// - Store holds 1024 points of eight bits.
// - Output select follows the buffered marker level control.
// - Grant when request line is held low while sync is low.
module shac_ctrl #(
   parameter int CUR_CYC = shac_pkg::CURSOR_CYC
) (
   input  wire logic                       mclk_i,                 // 20 MHz clock
   input  wire logic                       sys_rst_i,              // Sync reset
   input  wire logic                       sync_pulse_i,           // Sample sync
   input  wire logic                       cmp_up_i,               // Up comparator
   input  wire logic                       cmp_down_i,             // Down comparator
   input  wire logic                       overflow_i,             // Upper limit hit
   input  wire logic                       underflow_i,            // Lower limit hit
   input  wire logic                       bus_req_i,              // Request line level
   input  wire logic                       control_write_strobe_i, // Clears host address
   input  wire logic                       address_step_pulse_i,   // Steps host address
   input  wire logic                       host_rw_i,              // Host write when high
   input  wire logic                       save_first_i,           // Save-first mode
   input  wire logic                       acquire_i,              // Acquisition mode
   input  wire logic                       cursor_match_i,         // Cursor comparator
   input  wire logic                       marker_level_select_i,  // Marker select
   input  wire logic [shac_pkg::DAT_W-1:0] const_switch_i,         // Constant switch
   input  wire logic                       mem_bit_i,              // Serial bit to store
   input  wire logic [shac_pkg::BSEL_W-1:0] mem_bit_sel_i,         // Bit within point
   input  wire logic                       mem_bit_stb_i,          // Bit access strobe
   output logic      [shac_pkg::TRK_W-1:0] x_coord_o,              // Tracking DAC code
   output logic                            divide_start_strobe_o,  // Storage cycle start
   output logic      [shac_pkg::ADR_W-1:0] memory_address_lines_o, // Memory address
   output logic                            memory_address_oe_o,    // Address drive enable
   output logic                            mem_rw_o,               // Write when high
   output logic                            bus_req_o,              // Request line drive
   output logic                            bus_req_oe_o,           // Request pull enable
   output logic                            bus_grant_o,            // Access granted
   output logic                            trace_valid_flag_o,     // Valid display data
   output logic                            cursor_brighten_pulse_o,// Cursor one-shot
   output logic                            blank_o,                // Retrace blanking
   output logic                            const_bit_o,            // Constant bit
   output logic                            trace_out_sel_o,        // Marker routed
   output logic                            mem_bit_o               // Serial bit read
);
   import shac_pkg::*;

   logic [IN_N-1:0]  in_s, in_d_reg;
   logic             sync_rise, cw_rise, step_rise, cm_rise;
   shac_state_e      st_reg, st_next;
   logic [FLT_W-1:0] flt_reg, flt_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic [TRK_W-1:0] trk_reg, trk_next, hold_reg, hold_next, stp;
   logic             stb_reg, stb_next, up_ok, dn_ok, down_en;
   logic [DSP_W-1:0] dsp_reg, dsp_next;
   logic             trc_reg, trc_next, retr_reg, retr_next;
   logic             val_reg, val_next, blk_reg, blk_next;
   logic [CUR_W-1:0] cur_reg, cur_next;
   logic             curs_reg, curs_next;
   logic [ADR_W-1:0] hadr_reg, hadr_next, adr_reg, adr_next, mux_adr;
   logic             aoe_reg, aoe_next, rw_reg, rw_next;
   logic             boe_reg, boe_next, gnt_reg, gnt_next;
   logic             cb_reg, cb_next, osel_reg, osel_next, mb_reg;
   logic [DAT_W-1:0] store [0:MEM_DEPTH-1];

   shac_sync3 #(.W(IN_N)) u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       ({const_switch_i, marker_level_select_i, cursor_match_i,
                   acquire_i, save_first_i, host_rw_i, address_step_pulse_i,
                   control_write_strobe_i, bus_req_i, underflow_i, overflow_i,
                   cmp_down_i, cmp_up_i, sync_pulse_i}),
      .q_o       (in_s)
   );

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         in_d_reg <= '0;
      end else begin
         in_d_reg <= in_s;
      end
   end

   assign sync_rise = in_s[IN_SYNC] & ~in_d_reg[IN_SYNC];
   assign cw_rise   = in_s[IN_CW] & ~in_d_reg[IN_CW];
   assign step_rise = in_s[IN_STEP] & ~in_d_reg[IN_STEP];
   assign cm_rise   = in_s[IN_CMAT] & ~in_d_reg[IN_CMAT];

   // Memory bus arbitration
   always_comb begin
      st_next  = st_reg;
      flt_next = '0;
      case (st_reg)
         ST_ACQ, ST_DSP: begin
            if (in_s[IN_BREQ] && !in_s[IN_SYNC]) begin
               st_next = ST_REQ;
            end else begin
               st_next = in_s[IN_ACQ] ? ST_ACQ : ST_DSP;
            end
         end
         ST_REQ: begin
            flt_next = flt_reg + 4'h1;
            if (flt_reg == FLT_W'(FLOAT_CYC - 1)) begin
               st_next = ST_GNT;
            end
         end
         ST_GNT: begin
            if (sync_rise) begin
               st_next = in_s[IN_ACQ] ? ST_ACQ : ST_DSP;
            end
         end
         default: st_next = ST_DSP;
      endcase
      boe_next = (st_next == ST_REQ) || (st_next == ST_GNT);
      // grant while line held low and sync low
      gnt_next = (st_next == ST_GNT) && !in_s[IN_SYNC];
      // address floats through the request window
      aoe_next = (st_next != ST_REQ);
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st_reg  <= ST_DSP;
         flt_reg <= '0;
         boe_reg <= 1'b0;
         gnt_reg <= 1'b0;
         aoe_reg <= 1'b1;
      end else begin
         st_reg  <= st_next;
         flt_reg <= flt_next;
         boe_reg <= boe_next;
         gnt_reg <= gnt_next;
         aoe_reg <= aoe_next;
      end
   end

   // Tracking converter counter
   always_comb begin
      down_en  = (div_reg == DIV_W'(DOWN_DIV - 1));
      div_next = down_en ? '0 : div_reg + 6'h01;
      // step of two keeps odd codes only
      stp      = in_s[IN_SAVE] ? 10'h002 : 10'h001;
      // sync clocks up, halved base clocks down
      up_ok    = (st_reg == ST_ACQ) && sync_rise && in_s[IN_UP] && !in_s[IN_OVF]
                 && (trk_reg <= TRK_MAX - stp);
      dn_ok    = (st_reg == ST_ACQ) && down_en && in_s[IN_DN] && !in_s[IN_UNF]
                 && !up_ok && (trk_reg >= stp);
      trk_next = trk_reg;
      // up on sweep, down on retrace
      if (up_ok) begin
         trk_next = (trk_reg + stp) | {9'h000, in_s[IN_SAVE]};
      end else if (dn_ok) begin
         trk_next = (trk_reg - stp) | {9'h000, in_s[IN_SAVE]};
      end
      // strobe with every up-counted X value
      stb_next  = up_ok;
      hold_next = (st_reg == ST_ACQ) ? trk_next : hold_reg;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         div_reg  <= '0;
         trk_reg  <= TRK_RST;
         hold_reg <= TRK_RST;
         stb_reg  <= 1'b0;
      end else begin
         div_reg  <= div_next;
         trk_reg  <= trk_next;
         hold_reg <= hold_next;
         stb_reg  <= stb_next;
      end
   end

   // Display counter, cursor and blanking
   always_comb begin
      dsp_next  = dsp_reg;
      trc_next  = trc_reg;
      retr_next = retr_reg;
      if ((st_reg == ST_DSP) && sync_rise && !curs_reg) begin
         if (retr_reg) begin
            retr_next = 1'b0;
         end else begin
            dsp_next = dsp_reg + 9'h001;
            if (dsp_reg == '1) begin
               trc_next  = ~trc_reg;
               retr_next = 1'b1;
            end
         end
      end
      val_next = (st_reg == ST_DSP) && !retr_next;
      cur_next = cur_reg;
      // one-shot armed while trace valid low
      if (cur_reg != '0) begin
         cur_next = cur_reg - 8'h01;
      end else if (cm_rise && !val_reg) begin
         cur_next = CUR_W'(CUR_CYC);
      end
      curs_next = (cur_next != '0);
      // blank first-to-second retrace in marker cycles
      blk_next  = in_s[IN_MARK] && !val_next && trc_next;
      osel_next = in_s[IN_MARK];
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dsp_reg  <= '0;
         trc_reg  <= 1'b0;
         retr_reg <= 1'b0;
         val_reg  <= 1'b0;
         cur_reg  <= '0;
         curs_reg <= 1'b0;
         blk_reg  <= 1'b0;
         osel_reg <= 1'b0;
      end else begin
         dsp_reg  <= dsp_next;
         trc_reg  <= trc_next;
         retr_reg <= retr_next;
         val_reg  <= val_next;
         cur_reg  <= cur_next;
         curs_reg <= curs_next;
         blk_reg  <= blk_next;
         osel_reg <= osel_next;
      end
   end

   // Host address and memory line drive
   always_comb begin
      hadr_next = hadr_reg;
      if (cw_rise) begin
         hadr_next = '0;
      end else if (step_rise) begin
         hadr_next = hadr_reg + 10'h001;
      end
      mux_adr = in_s[IN_ACQ] ? hold_reg : {trc_reg, dsp_reg};
      // host drives memory only in grant
      if (st_next == ST_GNT) begin
         adr_next = hadr_reg;
         rw_next  = in_s[IN_RW];
      end else begin
         adr_next = mux_adr;
         rw_next  = in_s[IN_ACQ];
      end
      // address low bits pick constant bit
      cb_next = in_s[IN_CSW + 32'(adr_next[2:0])];
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         hadr_reg <= '0;
         adr_reg  <= '0;
         rw_reg   <= 1'b0;
         cb_reg   <= 1'b0;
      end else begin
         hadr_reg <= hadr_next;
         adr_reg  <= adr_next;
         rw_reg   <= rw_next;
         cb_reg   <= cb_next;
      end
   end

   // 1024 points of eight bits, serial bit access
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mb_reg <= 1'b0;
      end else if (mem_bit_stb_i) begin
         if (rw_reg) begin
            store[adr_reg][mem_bit_sel_i] <= mem_bit_i;
         end
         mb_reg <= store[adr_reg][mem_bit_sel_i];
      end
   end

   assign x_coord_o               = trk_reg;
   assign divide_start_strobe_o   = stb_reg;
   assign memory_address_lines_o  = adr_reg;
   assign memory_address_oe_o     = aoe_reg;
   assign mem_rw_o                = rw_reg;
   assign bus_req_o               = 1'b0;
   assign bus_req_oe_o            = boe_reg;
   assign bus_grant_o             = gnt_reg;
   assign trace_valid_flag_o      = val_reg;
   assign cursor_brighten_pulse_o = curs_reg;
   assign blank_o                 = blk_reg;
   assign const_bit_o             = cb_reg;
   assign trace_out_sel_o         = osel_reg;
   assign mem_bit_o               = mb_reg;

   property p_float;
      @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(bus_req_oe_o) |-> (!memory_address_oe_o) [*8] ##1 memory_address_oe_o;
   endproperty
   a_float: assert property (p_float) else $error("address float not eight cycles");

   property p_grant;
      @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(bus_grant_o) |-> bus_req_oe_o && $past(bus_req_oe_o, 8);
   endproperty
   a_grant: assert property (p_grant) else $error("grant without held request");

   property p_up;
      @(posedge mclk_i) disable iff (sys_rst_i)
      divide_start_strobe_o |-> x_coord_o > $past(x_coord_o);
   endproperty
   a_up: assert property (p_up) else $error("strobe without up-count");

   property p_save;
      @(posedge mclk_i) disable iff (sys_rst_i)
      ($changed(x_coord_o) && $past(in_s[IN_SAVE])) |-> x_coord_o[0];
   endproperty
   a_save: assert property (p_save) else $error("even code in save mode");

   property p_limit;
      @(posedge mclk_i) disable iff (sys_rst_i)
      $past(in_s[IN_OVF]) |-> x_coord_o <= $past(x_coord_o);
   endproperty
   a_limit: assert property (p_limit) else $error("count past overflow");

   property p_dir;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (x_coord_o < $past(x_coord_o)) |-> $past(in_s[IN_DN]);
   endproperty
   a_dir: assert property (p_dir) else $error("down-count without down input");

   property p_cursor;
      @(posedge mclk_i) disable iff (sys_rst_i)
      cursor_brighten_pulse_o |=> $stable(dsp_reg);
   endproperty
   a_cursor: assert property (p_cursor) else $error("display moved under cursor");

   property p_host;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (st_reg == ST_GNT) |-> memory_address_lines_o == $past(hadr_reg);
   endproperty
   a_host: assert property (p_host) else $error("host address not on lines");

   property p_valid;
      @(posedge mclk_i) disable iff (sys_rst_i)
      retr_reg |-> !trace_valid_flag_o;
   endproperty
   a_valid: assert property (p_valid) else $error("trace valid during retrace");
endmodule : shac_ctrl

// ---- shac_host_model.sv ----
// Behavioural model of the host interface that borrows the memory bus
module shac_host_model (
   input  wire logic       mclk_i,     // System clock
   input  wire logic       want_i,     // Bench asks for one access
   input  wire logic       grant_i,    // Grant from controller
   input  wire logic [3:0] lag_i,      // Extra cycles before stepping
   output logic            pull_low_o, // Host pulls request line low
   output logic            step_o      // Address step pulse
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      pull_low_o = 1'b1;
      step_o     = 1'b0;
      forever begin
         @(negedge mclk_i);
         if (want_i) begin
            pull_low_o = 1'b0;
            @(negedge mclk_i iff grant_i);
            @(negedge mclk_i iff !grant_i);
            pull_low_o = 1'b1;
            repeat (lag_i) @(negedge mclk_i);
            step_o = 1'b1;
            repeat (6) @(negedge mclk_i);
            step_o = 1'b0;
         end
      end
   end
endmodule : shac_host_model

// ---- test_storage_horizontal_address_ctrl.sv ----
// Self-checking bench for the storage horizontal address controller
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
   $display("BAD %0t mismatch got %0h exp %0h", $time, (got), (exp)); end end
module test_storage_horizontal_address_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import shac_pkg::*;

   logic             mclk_i = 1'b0;
   logic             sys_rst_i, sync, cmp_up, cmp_down, ovf, unf, cw, rw, save, acq;
   logic             mark, want, cm, mbi, mstb;
   logic [BSEL_W-1:0] msel;
   logic [DAT_W-1:0] csw;
   logic [3:0]       lag;
   logic [TRK_W-1:0] x_coord;
   logic [ADR_W-1:0] lines;
   logic             strb, addr_oe, mem_rw, req_o, req_oe, grant, valid;
   logic             curs, blank, cbit, osel, mbit, pull_low, step;
   wire              bus_line;
   int               n_fail = 0;
   int               check_count = 0;
   int               seed = 22;
   int               mx, ma, k, cnt, base, dv;
   int               n_strobe = 0;
   int               n_curs = 0;
   localparam int    CUR_SIM = 4;

   always #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
   // Pulled-up request line, low if either side pulls
   assign bus_line = ~((req_oe & ~req_o) | pull_low);
   always @(posedge mclk_i) if (strb === 1'b1) n_strobe++;
   always @(posedge mclk_i) if (curs === 1'b1) n_curs++;

   shac_ctrl #(.CUR_CYC(CUR_SIM)) i_dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sync_pulse_i(sync),
      .cmp_up_i(cmp_up), .cmp_down_i(cmp_down), .overflow_i(ovf), .underflow_i(unf),
      .bus_req_i(bus_line), .control_write_strobe_i(cw), .address_step_pulse_i(step),
      .host_rw_i(rw), .save_first_i(save), .acquire_i(acq), .cursor_match_i(cm),
      .marker_level_select_i(mark), .const_switch_i(csw), .mem_bit_i(mbi),
      .mem_bit_sel_i(msel), .mem_bit_stb_i(mstb), .x_coord_o(x_coord),
      .divide_start_strobe_o(strb), .memory_address_lines_o(lines),
      .memory_address_oe_o(addr_oe), .mem_rw_o(mem_rw), .bus_req_o(req_o),
      .bus_req_oe_o(req_oe), .bus_grant_o(grant), .trace_valid_flag_o(valid),
      .cursor_brighten_pulse_o(curs), .blank_o(blank), .const_bit_o(cbit),
      .trace_out_sel_o(osel), .mem_bit_o(mbit)
   );

   shac_host_model i_host (
      .mclk_i(mclk_i), .want_i(want), .grant_i(grant), .lag_i(lag),
      .pull_low_o(pull_low), .step_o(step)
   );

   task automatic idle(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : idle

   task automatic pulse_sync();
      sync = 1'b1;
      idle(6);
      sync = 1'b0;
      idle(6);
   endtask : pulse_sync

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (20000) @(posedge mclk_i);
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      sys_rst_i = 1'b1;
      {sync, cmp_up, cmp_down, ovf, unf, cw, rw, save, acq, mark, want, cm, mbi, mstb} = '0;
      msel = 3'h0;
      csw = 8'h00;
      lag = 4'h0;
      idle(5);
      sys_rst_i = 1'b0;
      idle(2);
      `CHK(addr_oe, 1'b1)
      `CHK(x_coord, 10'h000)
      `CHK(req_oe, 1'b0)
      `CHK(grant, 1'b0)
      `CHK(req_o, 1'b0)
      $display("reset test done");

      // Display counting, constant pick and output select
      csw = 8'($random(seed));
      mark = 1'b1;
      k = 3 + ($random(seed) & 3);
      repeat (k) pulse_sync();
      `CHK(lines, {1'b0, 9'(k)})
      `CHK(cbit, csw[k % 8])
      `CHK(osel, 1'b1)
      dv = k;
      $display("display test done");

      // Host address clear, grant and step
      cw = 1'b1;
      idle(6);
      cw = 1'b0;
      idle(6);
      ma = 0;
      for (int a = 0; a < 3; a++) begin
         if (a == 2) begin
            cw = 1'b1;
            idle(6);
            cw = 1'b0;
            idle(6);
            ma = 0;
         end
         rw = 1'($random(seed));
         lag = 4'(a * 5);
         want = 1'b1;
         cnt = 0;
         while (req_oe !== 1'b1 && cnt < 40) begin
            idle(1);
            cnt++;
         end
         want = 1'b0;
         cnt = 0;
         while (addr_oe !== 1'b1 && cnt < 20) begin
            cnt++;
            idle(1);
         end
         `CHK(cnt, FLOAT_CYC)
         `CHK(grant, 1'b1)
         `CHK(lines, 10'(ma))
         `CHK(mem_rw, rw)
         sync = 1'b1;
         idle(6);
         `CHK(grant, 1'b0)
         `CHK(req_oe, 1'b0)
         `CHK(addr_oe, 1'b1)
         sync = 1'b0;
         idle(30);
         ma++;
      end
      $display("bus test done");

      // Tracking up-counts, strobes and limit
      acq = 1'b1;
      cmp_up = 1'b1;
      mx = 0;
      idle(6);
      `CHK(valid, 1'b0)
      base = n_strobe;
      k = 3 + ($random(seed) & 3);
      repeat (k) begin
         pulse_sync();
         mx++;
         `CHK(x_coord, 10'(mx))
         `CHK(lines, 10'(mx))
      end
      `CHK(n_strobe - base, k)
      ovf = 1'b1;
      idle(6);
      pulse_sync();
      `CHK(x_coord, 10'(mx))
      `CHK(n_strobe - base, k)
      $display("up test done");

      // Down-counts at the halved base rate
      ovf = 1'b0;
      cmp_up = 1'b0;
      cmp_down = 1'b1;
      for (int d = 0; d < 2; d++) begin
         cnt = 0;
         while (x_coord === 10'(mx) && cnt < 100) begin
            idle(1);
            cnt++;
         end
         mx--;
         `CHK(x_coord, 10'(mx))
         if (d == 1) `CHK(cnt, DOWN_DIV)
      end
      unf = 1'b1;
      idle(200);
      `CHK(x_coord, 10'(mx))
      `CHK(n_strobe - base, k)
      $display("down test done");

      // Save-first mode keeps odd codes only
      unf = 1'b0;
      cmp_down = 1'b0;
      cmp_up = 1'b1;
      save = 1'b1;
      idle(6);
      pulse_sync();
      mx = (mx + 2) | 1;
      `CHK(x_coord, 10'(mx))
      pulse_sync();
      mx = mx + 2;
      `CHK(x_coord, 10'(mx))
      $display("save test done");

      // Bit write then read back at one address
      mbi = 1'($random(seed));
      msel = 3'($random(seed));
      mstb = 1'b1;
      idle(1);
      mbi = ~mbi;
      idle(1);
      mstb = 1'b0;
      idle(1);
      `CHK(mbit, ~mbi)
      $display("memory test done");

      // Cursor pulse holds the display counter
      base = n_curs;
      acq = 1'b0;
      cm = 1'b1;
      idle(1);
      pulse_sync();
      `CHK(lines, {1'b0, 9'(dv)})
      `CHK(n_curs - base, CUR_SIM)
      `CHK(valid, 1'b1)
      cm = 1'b0;
      pulse_sync();
      dv++;
      `CHK(lines, {1'b0, 9'(dv)})
      $display("cursor test done");

      // Display wrap, retrace and blanking
      repeat (511 - dv) begin
         sync = 1'b1;
         idle(3);
         sync = 1'b0;
         idle(3);
      end
      `CHK(lines, 10'h1FF)
      pulse_sync();
      `CHK(lines, 10'h200)
      `CHK(valid, 1'b0)
      `CHK(blank, 1'b1)
      pulse_sync();
      `CHK(lines, 10'h200)
      `CHK(valid, 1'b1)
      `CHK(blank, 1'b0)
      $display("wrap test done");
      report_and_stop();
   end
endmodule : test_storage_horizontal_address_ctrl
